// ==== bsl_pkg.sv ====
// Constants and types shared by the start-up configuration latch
package bsl_pkg;

  // ==========================================================================
  // Configuration pin layout
  localparam int BSL_NUM_STRAPS = 5;
  localparam int BSL_BIT_LDO = 0;
  localparam int BSL_BIT_PRI = 1;
  localparam int BSL_BIT_SEC = 2;
  localparam int BSL_BIT_LOG = 3;
  localparam int BSL_BIT_SDIO = 4;

  // ==========================================================================
  // Weak pull defaults, one bit per pin, set means pull-up
  localparam logic [4:0] BSL_PULL_UP_MASK = 5'h1a;
  // Value held by the latches before the first capture
  localparam logic [4:0] BSL_STRAP_RST = BSL_PULL_UP_MASK;

  // ==========================================================================
  // Decoded settings
  localparam logic BSL_LDO_3V3 = 1'h0;
  localparam logic BSL_LDO_1V8 = 1'h1;
  localparam logic BSL_EDGE_FALL = 1'h0;
  localparam logic BSL_EDGE_RISE = 1'h1;
  localparam logic BSL_UART_IDLE = 1'h1;
  localparam logic BSL_OVR_RST = 1'h0;

  typedef enum logic [1:0] {
    BSL_ST_STRAP = 2'h0,
    BSL_ST_BOOT = 2'h1,
    BSL_ST_RUN = 2'h2
  } bsl_state_type;

  typedef enum logic [1:0] {
    BSL_BOOT_SPI = 2'h0,
    BSL_BOOT_DOWNLOAD = 2'h1,
    BSL_BOOT_RESERVED = 2'h2
  } bsl_boot_type;

endpackage

// ==== bsl_strap_pad.sv ====
// One configuration pin: weak pull and capture at start-up, pass-through later
`timescale 1ns/1ns
module bsl_strap_pad #(
  parameter logic PULL_UP = 1'h0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Start-up control
  input wire logic strap_window,
  input wire logic capture,
  // Pin side
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic pull_up_en,
  output logic pull_down_en,
  // Functional side
  input wire logic func_o,
  input wire logic func_oe,
  output logic func_i,
  // Latched level
  output logic strap_bit_q
);

  logic strap_bit_d;

  // ==========================================================================
  // Pin ownership
  always_comb begin
    pin_o = strap_window ? 1'h0 : func_o;
    pin_oe = strap_window ? 1'h0 : func_oe;
    pull_up_en = strap_window & PULL_UP;
    pull_down_en = strap_window & ~PULL_UP;
    func_i = pin_i;
  end

  // ==========================================================================
  // Latch
  always_comb begin
    strap_bit_d = capture ? pin_i : strap_bit_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_bit_q <= PULL_UP;
    end else begin
      strap_bit_q <= strap_bit_d;
    end
  end

endmodule // bsl_strap_pad

// ==== bsl_boot_strap_latch.sv ====
// Start-up configuration latch: capture, decode, firmware override
`timescale 1ns/1ns
module bsl_boot_strap_latch
  import bsl_pkg::*;
#(
  parameter int NUM_STRAPS = bsl_pkg::BSL_NUM_STRAPS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration pins, one bit per pin
  input wire logic [NUM_STRAPS-1:0] strap_pin_i,
  output logic [NUM_STRAPS-1:0] strap_pin_o,
  output logic [NUM_STRAPS-1:0] strap_pin_oe,
  output logic [NUM_STRAPS-1:0] strap_pull_up_en,
  output logic [NUM_STRAPS-1:0] strap_pull_down_en,
  // Functional use of the same pins
  input wire logic [NUM_STRAPS-1:0] func_o,
  input wire logic [NUM_STRAPS-1:0] func_oe,
  output logic [NUM_STRAPS-1:0] func_i,
  // Boot progress
  input wire logic boot_done,
  output logic boot_active,
  output bsl_pkg::bsl_boot_type boot_mode,
  // Boot log
  input wire logic uart_tx_core,
  output logic first_uart_transmit_line,
  // Firmware override
  input wire logic cfg_wr,
  input wire logic cfg_ldo_ovr_en,
  input wire logic cfg_ldo_ovr_val,
  input wire logic cfg_sdio_ovr_en,
  input wire logic cfg_sdio_in_rising,
  input wire logic cfg_sdio_out_rising,
  // Status and decoded settings
  output logic [NUM_STRAPS-1:0] strap_status,
  output logic strap_valid,
  output logic ldo_sel_1v8,
  output logic sdio_in_rising,
  output logic sdio_out_rising
);
  import bsl_pkg::*;

  // ==========================================================================
  // Elaboration check
  generate
    if (NUM_STRAPS != BSL_NUM_STRAPS) begin : g_bad_count
      $error("Configuration latch serves exactly five pins");
    end
  endgenerate

  // ==========================================================================
  // Decoders
  function automatic bsl_boot_type bsl_boot_f(input logic pri, input logic sec);
    bsl_boot_type mode;
    if (pri) begin
      mode = BSL_BOOT_SPI;
    end else if (!sec) begin
      mode = BSL_BOOT_DOWNLOAD;
    end else begin
      mode = BSL_BOOT_RESERVED;
    end
    return mode;
  endfunction

  function automatic logic bsl_ldo_f(input logic bit_v);
    return bit_v ? BSL_LDO_1V8 : BSL_LDO_3V3;
  endfunction

  function automatic logic bsl_edge_f(input logic bit_v);
    return bit_v ? BSL_EDGE_RISE : BSL_EDGE_FALL;
  endfunction

  // ==========================================================================
  // Sequencing
  bsl_state_type state_q;
  bsl_state_type state_d;
  logic strap_window;
  logic capture;
  logic valid_q;
  logic valid_d;

  always_comb begin
    state_d = state_q;
    valid_d = valid_q;
    case (state_q)
      BSL_ST_STRAP: begin
        state_d = BSL_ST_BOOT;
        valid_d = 1'h1;
      end
      BSL_ST_BOOT: begin
        if (boot_done) begin
          state_d = BSL_ST_RUN;
        end
      end
      BSL_ST_RUN: begin
        state_d = BSL_ST_RUN;
      end
      default: begin
        state_d = BSL_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= BSL_ST_STRAP;
      valid_q <= 1'h0;
    end else begin
      state_q <= state_d;
      valid_q <= valid_d;
    end
  end

  // Pins stay in start-up mode through reset and the capture cycle
  assign strap_window = rst | (state_q == BSL_ST_STRAP);
  assign capture = ~rst & (state_q == BSL_ST_STRAP);

  // ==========================================================================
  // Pins and latches
  logic [NUM_STRAPS-1:0] strap_bits;

  generate
    for (genvar i = 0; i < NUM_STRAPS; i++) begin : g_pad
      bsl_strap_pad #(
        .PULL_UP(BSL_PULL_UP_MASK[i])
      ) u_pad (
        .clk_sys(clk_sys),
        .rst(rst),
        .strap_window(strap_window),
        .capture(capture),
        .pin_i(strap_pin_i[i]),
        .pin_o(strap_pin_o[i]),
        .pin_oe(strap_pin_oe[i]),
        .pull_up_en(strap_pull_up_en[i]),
        .pull_down_en(strap_pull_down_en[i]),
        .func_o(func_o[i]),
        .func_oe(func_oe[i]),
        .func_i(func_i[i]),
        .strap_bit_q(strap_bits[i])
      );
    end
  endgenerate

  // Read-only view, bit order fixed by the package positions
  assign strap_status = strap_bits;
  assign strap_valid = valid_q;
  assign boot_active = (state_q != BSL_ST_RUN);

  // ==========================================================================
  // Firmware override, accepted only once boot has finished
  logic ldo_ovr_en_q;
  logic ldo_ovr_en_d;
  logic ldo_ovr_val_q;
  logic ldo_ovr_val_d;
  logic sdio_ovr_en_q;
  logic sdio_ovr_en_d;
  logic sdio_in_ovr_q;
  logic sdio_in_ovr_d;
  logic sdio_out_ovr_q;
  logic sdio_out_ovr_d;
  logic cfg_accept;

  assign cfg_accept = cfg_wr & (state_q == BSL_ST_RUN);

  always_comb begin
    ldo_ovr_en_d = ldo_ovr_en_q;
    ldo_ovr_val_d = ldo_ovr_val_q;
    sdio_ovr_en_d = sdio_ovr_en_q;
    sdio_in_ovr_d = sdio_in_ovr_q;
    sdio_out_ovr_d = sdio_out_ovr_q;
    if (cfg_accept) begin
      ldo_ovr_en_d = cfg_ldo_ovr_en;
      ldo_ovr_val_d = cfg_ldo_ovr_val;
      sdio_ovr_en_d = cfg_sdio_ovr_en;
      sdio_in_ovr_d = cfg_sdio_in_rising;
      sdio_out_ovr_d = cfg_sdio_out_rising;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ldo_ovr_en_q <= BSL_OVR_RST;
      ldo_ovr_val_q <= BSL_OVR_RST;
      sdio_ovr_en_q <= BSL_OVR_RST;
      sdio_in_ovr_q <= BSL_OVR_RST;
      sdio_out_ovr_q <= BSL_OVR_RST;
    end else begin
      ldo_ovr_en_q <= ldo_ovr_en_d;
      ldo_ovr_val_q <= ldo_ovr_val_d;
      sdio_ovr_en_q <= sdio_ovr_en_d;
      sdio_in_ovr_q <= sdio_in_ovr_d;
      sdio_out_ovr_q <= sdio_out_ovr_d;
    end
  end

  // ==========================================================================
  // Decoded outputs
  logic ldo_q;
  logic ldo_d;
  logic sdio_in_q;
  logic sdio_in_d;
  logic sdio_out_q;
  logic sdio_out_d;
  logic uart_q;
  logic uart_d;
  bsl_boot_type boot_q;
  bsl_boot_type boot_d;

  always_comb begin
    ldo_d = bsl_ldo_f(strap_bits[BSL_BIT_LDO]);
    if (ldo_ovr_en_q) begin
      ldo_d = ldo_ovr_val_q;
    end
    sdio_in_d = bsl_edge_f(strap_bits[BSL_BIT_LOG]);
    sdio_out_d = bsl_edge_f(strap_bits[BSL_BIT_SDIO]);
    if (sdio_ovr_en_q) begin
      sdio_in_d = sdio_in_ovr_q;
      sdio_out_d = sdio_out_ovr_q;
    end
    boot_d = bsl_boot_f(strap_bits[BSL_BIT_PRI], strap_bits[BSL_BIT_SEC]);
    // Log is held back until boot has finished when the log bit is low
    uart_d = uart_tx_core;
    if (boot_active && !strap_bits[BSL_BIT_LOG]) begin
      uart_d = BSL_UART_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ldo_q <= BSL_LDO_3V3;
      sdio_in_q <= BSL_EDGE_FALL;
      sdio_out_q <= BSL_EDGE_FALL;
      boot_q <= BSL_BOOT_SPI;
      uart_q <= BSL_UART_IDLE;
    end else begin
      ldo_q <= ldo_d;
      sdio_in_q <= sdio_in_d;
      sdio_out_q <= sdio_out_d;
      boot_q <= boot_d;
      uart_q <= uart_d;
    end
  end

  assign ldo_sel_1v8 = ldo_q;
  assign sdio_in_rising = sdio_in_q;
  assign sdio_out_rising = sdio_out_q;
  assign boot_mode = boot_q;
  assign first_uart_transmit_line = uart_q;

  // ==========================================================================
  // Assertions
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_capture;
    state_q == BSL_ST_STRAP;
  endsequence

  sequence s_ovr_write;
    cfg_wr && state_q == BSL_ST_RUN && cfg_ldo_ovr_en ##1 !cfg_wr;
  endsequence

  property p_capture;
    s_capture |=> strap_bits == $past(strap_pin_i) && valid_q;
  endproperty
  a_capture: assert property (p_capture) else $error("pin levels not captured");

  property p_hold;
    state_q != BSL_ST_STRAP |=> $stable(strap_bits);
  endproperty
  a_hold: assert property (p_hold) else $error("latched bits changed after capture");

  property p_pulls;
    state_q == BSL_ST_STRAP |-> strap_pull_up_en == BSL_PULL_UP_MASK
      && strap_pull_down_en == ~BSL_PULL_UP_MASK && strap_pin_oe == '0;
  endproperty
  a_pulls: assert property (p_pulls) else $error("wrong pulls during start-up");

  property p_release;
    state_q != BSL_ST_STRAP |-> strap_pin_oe == func_oe && strap_pin_o == func_o
      && strap_pull_up_en == '0 && strap_pull_down_en == '0;
  endproperty
  a_release: assert property (p_release) else $error("pins not released");

  property p_status;
    $rose(strap_valid) |-> strap_status == $past(strap_pin_i);
  endproperty
  a_status: assert property (p_status) else $error("status does not show captured bits");

  property p_ldo;
    valid_q && !ldo_ovr_en_q |=> ldo_sel_1v8 == $past(strap_bits[BSL_BIT_LDO]);
  endproperty
  a_ldo: assert property (p_ldo) else $error("voltage select not from latched bit");

  property p_boot;
    valid_q |=> (strap_bits[BSL_BIT_PRI] && boot_mode == BSL_BOOT_SPI)
      || (!strap_bits[BSL_BIT_PRI] && !strap_bits[BSL_BIT_SEC] && boot_mode == BSL_BOOT_DOWNLOAD)
      || (!strap_bits[BSL_BIT_PRI] && strap_bits[BSL_BIT_SEC] && boot_mode == BSL_BOOT_RESERVED);
  endproperty
  a_boot: assert property (p_boot) else $error("boot mode decode wrong");

  property p_log;
    boot_active && valid_q && !strap_bits[BSL_BIT_LOG] |=> first_uart_transmit_line == BSL_UART_IDLE;
  endproperty
  a_log: assert property (p_log) else $error("boot log not silenced");

  property p_sdio;
    valid_q && !sdio_ovr_en_q |=> sdio_in_rising == $past(strap_bits[BSL_BIT_LOG])
      && sdio_out_rising == $past(strap_bits[BSL_BIT_SDIO]);
  endproperty
  a_sdio: assert property (p_sdio) else $error("SDIO edge decode wrong");

  property p_override;
    s_ovr_write |=> ldo_sel_1v8 == $past(cfg_ldo_ovr_val, 2);
  endproperty
  a_override: assert property (p_override) else $error("voltage override not applied");

  property p_no_early_ovr;
    cfg_wr && state_q != BSL_ST_RUN |=> $stable(ldo_ovr_en_q) && $stable(sdio_ovr_en_q);
  endproperty
  a_no_early_ovr: assert property (p_no_early_ovr) else $error("override taken during boot");

endmodule // bsl_boot_strap_latch

// ==== bsl_board_model.sv ====
// Board-side model: pull resistors or host drive on the configuration pins
`timescale 1ns/1ns
module bsl_board_model (
  // Clock
  input wire logic clk_sys,
  // Board setting of each pin
  input wire logic [4:0] host_drive,
  input wire logic [4:0] host_val,
  // Device side of the pins
  input wire logic [4:0] pin_o,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] pull_up_en,
  input wire logic [4:0] pull_down_en,
  // Resolved pin level
  output logic [4:0] pin_level
);
  logic [4:0] float_q = 5'h0a;

  // An undriven pin without pull wanders rather than keeping a level
  always_ff @(posedge clk_sys) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_o[i];
      end else if (host_drive[i]) begin
        pin_level[i] = host_val[i];
      end else if (pull_up_en[i]) begin
        pin_level[i] = 1'b1;
      end else if (pull_down_en[i]) begin
        pin_level[i] = 1'b0;
      end else begin
        pin_level[i] = float_q[i];
      end
    end
  end
endmodule // bsl_board_model

// ==== tb.sv ====
// Self-checking testbench of the start-up configuration latch
`timescale 1ns/1ns
module tb;
  import bsl_pkg::*;
  logic clk_sys, rst, boot_done, boot_active, uart_tx_core, uart_line, cfg_wr;
  logic cfg_ldo_ovr_en, cfg_ldo_ovr_val, cfg_sdio_ovr_en, cfg_sdio_in_rising, cfg_sdio_out_rising;
  logic strap_valid, ldo_sel_1v8, sdio_in_rising, sdio_out_rising;
  logic [4:0] pin_i, pin_o, pin_oe, pull_up, pull_dn, func_o, func_oe, func_i, status;
  logic [4:0] host_drive, host_val, exp, ov;
  bsl_boot_type boot_mode;
  int seed, bad_count, cmp_count;

  bsl_boot_strap_latch u_dut (.clk_sys(clk_sys), .rst(rst), .strap_pin_i(pin_i), .strap_pin_o(pin_o),
    .strap_pin_oe(pin_oe), .strap_pull_up_en(pull_up), .strap_pull_down_en(pull_dn), .func_o(func_o),
    .func_oe(func_oe), .func_i(func_i), .boot_done(boot_done), .boot_active(boot_active),
    .boot_mode(boot_mode), .uart_tx_core(uart_tx_core), .first_uart_transmit_line(uart_line),
    .cfg_wr(cfg_wr), .cfg_ldo_ovr_en(cfg_ldo_ovr_en), .cfg_ldo_ovr_val(cfg_ldo_ovr_val),
    .cfg_sdio_ovr_en(cfg_sdio_ovr_en), .cfg_sdio_in_rising(cfg_sdio_in_rising),
    .cfg_sdio_out_rising(cfg_sdio_out_rising), .strap_status(status), .strap_valid(strap_valid),
    .ldo_sel_1v8(ldo_sel_1v8), .sdio_in_rising(sdio_in_rising), .sdio_out_rising(sdio_out_rising));

  bsl_board_model u_board (.clk_sys(clk_sys), .host_drive(host_drive), .host_val(host_val),
    .pin_o(pin_o), .pin_oe(pin_oe), .pull_up_en(pull_up), .pull_down_en(pull_dn), .pin_level(pin_i));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Override fields: bit0 ldo enable, 1 ldo value, 2 sdio enable, 3 input edge, 4 output edge
  task automatic wr(input logic [4:0] v);
    {cfg_sdio_out_rising, cfg_sdio_in_rising, cfg_sdio_ovr_en, cfg_ldo_ovr_val, cfg_ldo_ovr_en} = v;
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (boot_active !== 1'b0 && n < 8) begin
      step(1);
      n++;
    end
    if (boot_active !== 1'b0) begin
      bad_count++;
      $display("ERROR %0t boot phase did not end", $time);
      close_out();
    end
  endtask

  function automatic bsl_boot_type exp_boot(input logic [4:0] s);
    if (s[1]) return BSL_BOOT_SPI;
    return s[2] ? BSL_BOOT_RESERVED : BSL_BOOT_DOWNLOAD;
  endfunction

  initial begin
    seed = 32'hc8ac;
    bad_count = 0;
    cmp_count = 0;
    cfg_wr = 1'b0;
    wr(5'h00);
    for (int p = 0; p < 32; p++) begin
      // Pattern 0 leaves every pin to the weak defaults, pattern 1 drives only the voltage pin, high
      host_val = p[4:0];
      host_drive = (p == 0) ? 5'h00 : (p == 1) ? 5'h01 : 5'($random(seed));
      func_o = 5'($random(seed));
      func_oe = 5'($random(seed));
      uart_tx_core = 1'b1;
      boot_done = 1'b0;
      rst = 1'b1;
      step(10);
      chk(pull_up === 5'h1a && pull_dn === 5'h05, "pulls during reset");
      chk(pin_oe === 5'h00 && strap_valid === 1'b0, "pins idle during reset");
      exp = (host_val & host_drive) | (5'h1a & ~host_drive);
      rst = 1'b0;
      step(1);
      // Late pin changes must not reach the latches
      host_val = ~host_val;
      step(2);
      chk(status === exp && strap_valid === 1'b1, "latched bits");
      chk(pull_up === 5'h00 && pull_dn === 5'h00 && pin_oe === func_oe, "pins released");
      chk(pin_o === func_o && func_i === pin_i, "functional path");
      chk(boot_mode === exp_boot(exp), "boot mode");
      chk(ldo_sel_1v8 === exp[0], "ldo select");
      chk(sdio_in_rising === exp[3] && sdio_out_rising === exp[4], "sdio edges");
      uart_tx_core = 1'b0;
      step(2);
      chk(uart_line === ~exp[3], "boot log gating");
      cfg_wr = 1'b1;
      wr({~exp[4], ~exp[3], 1'b1, ~exp[0], 1'b1});
      step(1);
      cfg_wr = 1'b0;
      step(2);
      chk(ldo_sel_1v8 === exp[0] && sdio_in_rising === exp[3], "override refused while booting");
      boot_done = 1'b1;
      wait_run();
      // The line register takes the first unsilenced value one edge after boot ends
      step(1);
      chk(uart_line === 1'b0, "uart passes after boot");
      ov = 5'($random(seed));
      cfg_wr = 1'b1;
      wr(~ov);
      step(1);
      wr(ov);
      step(1);
      cfg_wr = 1'b0;
      step(2);
      chk(ldo_sel_1v8 === (ov[0] ? ov[1] : exp[0]), "ldo override");
      chk(sdio_in_rising === (ov[2] ? ov[3] : exp[3]), "sdio input override");
      chk(sdio_out_rising === (ov[2] ? ov[4] : exp[4]), "sdio output override");
      chk(status === exp, "status held");
      $display("test %0d done", p);
    end
    close_out();
  end
endmodule // tb
